// file: bench/ufpc_regs_tb.sv
// Purpose: Self-checking bench for the FIFO partition register group
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Expected read values are queued and checked by a separate monitor
`timescale 1ns/1ps
`include "ufpc_regs.svh"

module usb_fifo_partition_config_regs_tb_top;
   logic                      sys_clk;
   logic                      sys_rst;
   logic [`UFPC_ADDR_W-1:0]   reg_addr;
   logic [31:0]               reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic                      host_mode;
   ufpc_pkg::ufpc_queue_req_s queue_push;
   logic                      queue_pop;
   logic                      fifo_word_wr;
   logic                      fifo_word_tx;
   logic [31:0]               reg_rdata;
   ufpc_pkg::ufpc_fifo_part_s rx_part;
   ufpc_pkg::ufpc_fifo_part_s np_part;
   ufpc_pkg::ufpc_fifo_part_s per_part;
   ufpc_pkg::ufpc_core_cfg_s  core_cfg;
   logic                      supply_forced_valid;
   logic                      queue_accept;
   int                        n_errors;
   int                        n_compared;
   logic [63:0]               exp_q[$];
   logic [63:0]               e_mon;
   logic                      rd_d;
   logic [31:0]               v;
   logic [31:0]               cfg_vals[8];

   ufpc_regs u_dut
   (
      .sys_clk             (sys_clk),
      .sys_rst             (sys_rst),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .host_mode           (host_mode),
      .queue_push          (queue_push),
      .queue_pop           (queue_pop),
      .fifo_word_wr        (fifo_word_wr),
      .fifo_word_tx        (fifo_word_tx),
      .reg_rdata           (reg_rdata),
      .rx_part             (rx_part),
      .np_part             (np_part),
      .per_part            (per_part),
      .core_cfg            (core_cfg),
      .supply_forced_valid (supply_forced_valid),
      .queue_accept        (queue_accept)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic cmp_rd(input logic [31:0] g, input logic [63:0] e);
      n_compared++;
      if ((g & e[63:32]) !== (e[31:0] & e[63:32]))
      begin
         n_errors++;
         $display("[FAIL] %0t read %h expected %h", $time, g, e[31:0]);
      end
   endtask

   task automatic cmp_out(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t output %h expected %h", $time, g, e);
      end
   endtask

   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back({m, e});
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
   endtask

   // Kind 0 writes a FIFO word, 1 transmits one, 2 pops a queue entry
   task automatic strobe(input int k, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         if (k == 0) fifo_word_wr <= 1'b1;
         else if (k == 1) fifo_word_tx <= 1'b1;
         else queue_pop <= 1'b1;
         @(posedge sys_clk);
         fifo_word_wr <= 1'b0;
         fifo_word_tx <= 1'b0;
         queue_pop    <= 1'b0;
      end
   endtask

   task automatic push(input logic o, input logic [6:0] t, input logic acc);
      @(posedge sys_clk);
      queue_push <= {1'b1, o, t};
      @(posedge sys_clk);
      queue_push.valid <= 1'b0;
      @(negedge sys_clk);
      cmp_out({31'h0, queue_accept}, {31'h0, acc});
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk)
      rd_d <= reg_rd;

   always @(negedge sys_clk)
      if (rd_d === 1'b1)
      begin
         e_mon = exp_q.pop_front();
         cmp_rd(reg_rdata, e_mon);
      end

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      #25000;
      n_errors++;
      complete_run();
   end

   initial
   begin
      {sys_rst, reg_wr, reg_rd, queue_pop, fifo_word_wr} = 5'h10;
      {fifo_word_tx, host_mode, rd_d, reg_addr, reg_wdata} = '0;
      queue_push = '0;
      cfg_vals = '{32'h0001_0000, 32'h0004_0000, 32'h0008_0000,
                   32'h0010_0000, 32'h0020_0000, 32'h003d_0000,
                   32'h001d_0000, 32'h0};
      v = $urandom(49);
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(`UFPC_OFF_NP_STATUS, 32'h0008_0000, 32'hffff_0000);
      rd(`UFPC_OFF_RX_SIZE, 32'h0000_0200, '1);
      rd(`UFPC_OFF_NP_SIZE, 32'h0000_0200, '1);
      rd(`UFPC_OFF_CORE_CFG, 32'h0, '1);
      rd(`UFPC_OFF_PER_SIZE, 32'h0200_0600, '1);
      cmp_out(per_part, 32'h0200_0600);
      cmp_out(rx_part, 32'h0200_0000);
      $display("reset values done");
      v = $urandom();
      wr(`UFPC_OFF_IDENT, v);
      rd(`UFPC_OFF_IDENT, v, '1);
      wr(`UFPC_OFF_RX_SIZE, v & `UFPC_RX_MASK);
      rd(`UFPC_OFF_RX_SIZE, v & `UFPC_RX_MASK, '1);
      wr(`UFPC_OFF_PER_SIZE, ~v);
      rd(`UFPC_OFF_PER_SIZE, ~v, '1);
      cmp_out(per_part, ~v);
      wr(12'h040, v);
      rd(12'h040, 32'h0, '1);
      wr(`UFPC_OFF_NP_STATUS, 32'h7fff_ffff);
      rd(`UFPC_OFF_NP_STATUS, 32'h0008_0000, 32'hffff_0000);
      $display("register access done");
      foreach (cfg_vals[i])
      begin
         v = cfg_vals[i];
         wr(`UFPC_OFF_CORE_CFG, v);
         rd(`UFPC_OFF_CORE_CFG, v & `UFPC_CFG_MASK, '1);
         cmp_out(core_cfg, {v[21], v[20], v[19] & ~v[21],
                            v[18] & ~v[21], v[16]});
         cmp_out(supply_forced_valid, v[21]);
      end
      $display("core config done");
      host_mode <= 1'b1;
      wr(`UFPC_OFF_NP_SIZE, 32'h0010_0040);
      rd(`UFPC_OFF_NP_SIZE, 32'h0010_0040, '1);
      strobe(1, 20);
      rd(`UFPC_OFF_NP_STATUS, 32'd16, 32'hffff);
      strobe(0, 3);
      rd(`UFPC_OFF_NP_STATUS, 32'd13, 32'hffff);
      host_mode <= 1'b0;
      v = {16'h0010, 16'($urandom())};
      wr(`UFPC_OFF_NP_SIZE, v);
      rd(`UFPC_OFF_NP_SIZE, v, '1);
      cmp_out(np_part, v);
      $display("fifo space done");
      host_mode <= 1'b1;
      push(1'b1, 7'h2b, 1'b1);
      rd(`UFPC_OFF_NP_STATUS, 32'h2b07_000d, '1);
      host_mode <= 1'b0;
      push(1'b1, 7'h10, 1'b0);
      foreach (cfg_vals[i])
         if (i < 7)
            push(1'b0, {4'(i), 2'(i % 4 == 2 ? 3 : i % 4), 1'b0},
                 1'b1);
      push(1'b0, 7'h06, 1'b0);
      rd(`UFPC_OFF_NP_STATUS, 32'h2b00_000d, '1);
      strobe(2, 9);
      rd(`UFPC_OFF_NP_STATUS, 32'h0008_000d, 32'h00ff_ffff);
      host_mode <= 1'b1;
      push(1'b0, 7'h37, 1'b1);
      rd(`UFPC_OFF_NP_STATUS, 32'h3707_000d, '1);
      strobe(2, 1);
      push(1'b1, 7'h48, 1'b1);
      rd(`UFPC_OFF_NP_STATUS, 32'h4807_000d, '1);
      $display("request queue done");
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(`UFPC_OFF_RX_SIZE, 32'h0000_0200, '1);
      rd(`UFPC_OFF_PER_SIZE, 32'h0200_0600, '1);
      rd(`UFPC_OFF_NP_STATUS, 32'h0008_0000, 32'hffff_0000);
      cmp_out(rx_part, 32'h0200_0000);
      $display("mid-run reset done");
      complete_run();
   end
endmodule // usb_fifo_partition_config_regs_tb_top

// file: logic/ufpc_pkg.sv
// Purpose: Types for the FIFO partition register group
// Assumes: Nothing
// Notes:   Constants live in ufpc_regs.svh
package ufpc_pkg;

   typedef enum logic [1:0]
   {
      UFPC_ENTRY_TOKEN = 2'h0,
      UFPC_ENTRY_ZLP   = 2'h1,
      UFPC_ENTRY_RSVD  = 2'h2,
      UFPC_ENTRY_HALT  = 2'h3
   } ufpc_entry_e;

   typedef struct packed
   {
      logic [3:0]  number;
      ufpc_entry_e kind;
      logic        terminate;
   } ufpc_queue_top_s;

   typedef struct packed
   {
      logic [15:0] depth;
      logic [15:0] start;
   } ufpc_fifo_part_s;

   typedef struct packed
   {
      logic supply_sense_disable;
      logic frame_pulse_pad_enable;
      logic b_role_supply_sense_en;
      logic a_role_supply_sense_en;
      logic transceiver_power_on;
   } ufpc_core_cfg_s;

   typedef struct packed
   {
      logic                  valid;
      logic                  is_out;
      ufpc_pkg::ufpc_queue_top_s entry;
   } ufpc_queue_req_s;

endpackage

// file: logic/ufpc_regs.sv
// Purpose: FIFO partition, non-periodic status, core config and ident regs
// Assumes: Inputs synchronous to sys_clk; engines give one-cycle strobes
// Notes:   Read data valid the cycle after the read strobe only
`timescale 1ns/1ps
`include "ufpc_regs.svh"

module ufpc_regs
(
   input  wire logic                         sys_clk,
   input  wire logic                         sys_rst,
   input  wire logic [`UFPC_ADDR_W-1:0]      reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic                         host_mode,
   input  wire ufpc_pkg::ufpc_queue_req_s    queue_push,
   input  wire logic                         queue_pop,
   input  wire logic                         fifo_word_wr,
   input  wire logic                         fifo_word_tx,
   output logic [31:0]                       reg_rdata,
   output ufpc_pkg::ufpc_fifo_part_s         rx_part,
   output ufpc_pkg::ufpc_fifo_part_s         np_part,
   output ufpc_pkg::ufpc_fifo_part_s         per_part,
   output ufpc_pkg::ufpc_core_cfg_s          core_cfg,
   output logic                              supply_forced_valid,
   output logic                              queue_accept
);

   logic [15:0]                 rx_depth_q;
   ufpc_pkg::ufpc_fifo_part_s   np_q;
   ufpc_pkg::ufpc_fifo_part_s   per_q;
   logic [31:0]                 cfg_q;
   logic [31:0]                 ident_q;
   ufpc_pkg::ufpc_queue_top_s   top_q;
   logic [7:0]                  q_free_q;
   logic [15:0]                 f_free_q;
   logic [15:0]                 f_free_d;
   logic                        push_ok;
   logic                        pop_ok;
   logic                        wr_ok;
   logic                        tx_ok;
   logic [31:0]                 status_w;
   logic [31:0]                 rdata_d;

   function automatic logic hit(input logic [`UFPC_ADDR_W-1:0] a,
                                input logic [`UFPC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Software-written registers

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rx_depth_q <= 16'(`UFPC_RST_RX_SIZE);
      else if (reg_wr && hit(reg_addr, `UFPC_OFF_RX_SIZE))
         rx_depth_q <= reg_wdata[15:0];
   end

   // Host: non-periodic FIFO; device: endpoint-0 FIFO, same storage
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         np_q <= `UFPC_RST_NP_SIZE;
      else if (reg_wr && hit(reg_addr, `UFPC_OFF_NP_SIZE))
         np_q <= reg_wdata;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         per_q <= `UFPC_RST_PER_SIZE;
      else if (reg_wr && hit(reg_addr, `UFPC_OFF_PER_SIZE))
         per_q <= reg_wdata;
   end

   // Reserved configuration bits are not stored and read as zero
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cfg_q <= `UFPC_RST_CORE_CFG;
      else if (reg_wr && hit(reg_addr, `UFPC_OFF_CORE_CFG))
         cfg_q <= reg_wdata & `UFPC_CFG_MASK;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ident_q <= `UFPC_RST_IDENT;
      else if (reg_wr && hit(reg_addr, `UFPC_OFF_IDENT))
         ident_q <= reg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Request queue and FIFO space tracking

   // Device mode queues IN requests only
   assign push_ok = queue_push.valid && (q_free_q != 8'h00)
                    && (host_mode || !queue_push.is_out);
   assign pop_ok  = queue_pop && (q_free_q != `UFPC_QUEUE_DEPTH);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         q_free_q <= `UFPC_QUEUE_DEPTH;
      else if (push_ok && !pop_ok)
         q_free_q <= q_free_q - 8'h01;
      else if (pop_ok && !push_ok)
         q_free_q <= q_free_q + 8'h01;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         top_q <= '0;
      else if (push_ok && q_free_q == `UFPC_QUEUE_DEPTH)
         top_q <= queue_push.entry;
   end

   assign wr_ok = fifo_word_wr && (f_free_q != 16'h0000);
   assign tx_ok = fifo_word_tx && (f_free_q < np_q.depth);

   always_comb
   begin
      f_free_d = f_free_q;
      if (wr_ok && !tx_ok)
         f_free_d = f_free_q - 16'h0001;
      else if (tx_ok && !wr_ok)
         f_free_d = f_free_q + 16'h0001;
      if (f_free_d > np_q.depth)
         f_free_d = np_q.depth;
      if (f_free_d > `UFPC_DEPTH_MAX)
         f_free_d = `UFPC_DEPTH_MAX;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         f_free_q <= 16'(`UFPC_RST_NP_STATUS);
      else
         f_free_q <= f_free_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   assign status_w = {1'b0, top_q, q_free_q, f_free_q};

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (reg_rd)
      begin
         if (hit(reg_addr, `UFPC_OFF_RX_SIZE))
            rdata_d = {16'h0000, rx_depth_q};
         else if (hit(reg_addr, `UFPC_OFF_NP_SIZE))
            rdata_d = np_q;
         else if (hit(reg_addr, `UFPC_OFF_NP_STATUS))
            rdata_d = status_w;
         else if (hit(reg_addr, `UFPC_OFF_CORE_CFG))
            rdata_d = cfg_q;
         else if (hit(reg_addr, `UFPC_OFF_IDENT))
            rdata_d = ident_q;
         else if (hit(reg_addr, `UFPC_OFF_PER_SIZE))
            rdata_d = per_q;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0000_0000;
      else
         reg_rdata <= rdata_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs to the FIFO engines and pads

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_part  <= '0;
         np_part  <= '0;
         per_part <= '0;
      end
      else
      begin
         rx_part  <= {rx_depth_q, 16'h0000};
         np_part  <= np_q;
         per_part <= per_q;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         core_cfg            <= '0;
         supply_forced_valid <= 1'b0;
         queue_accept        <= 1'b0;
      end
      else
      begin
         core_cfg.supply_sense_disable   <= cfg_q[`UFPC_CFG_SENSE_DIS];
         core_cfg.frame_pulse_pad_enable <= cfg_q[`UFPC_CFG_SOF_PAD];
         core_cfg.b_role_supply_sense_en <= cfg_q[`UFPC_CFG_B_SENSE]
                                            & ~cfg_q[`UFPC_CFG_SENSE_DIS];
         core_cfg.a_role_supply_sense_en <= cfg_q[`UFPC_CFG_A_SENSE]
                                            & ~cfg_q[`UFPC_CFG_SENSE_DIS];
         core_cfg.transceiver_power_on   <= cfg_q[`UFPC_CFG_PWR_ON];
         supply_forced_valid             <= cfg_q[`UFPC_CFG_SENSE_DIS];
         queue_accept                    <= push_ok;
      end
   end
   // sensing enables above follow bits 19 and 18, gated

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_rx_reset_value: assert property (@(posedge sys_clk)
      $fell(sys_rst) |-> rx_depth_q == 16'h0200)
      else $error("receive depth reset wrong");

   a_rx_write_store: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      reg_wr && reg_addr == `UFPC_OFF_RX_SIZE
      |=> rx_depth_q == $past(reg_wdata[15:0]))
      else $error("receive depth not stored");

   a_status_read_back: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      reg_rd && reg_addr == `UFPC_OFF_NP_STATUS
      |=> reg_rdata == $past(status_w))
      else $error("status read mismatch");

   a_queue_free_bound: assert property (@(posedge sys_clk)
      disable iff (sys_rst) q_free_q <= 8'h08)
      else $error("queue free above eight");

   a_device_rejects_out: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      queue_push.valid && queue_push.is_out && !host_mode
      |=> q_free_q == $past(q_free_q) || $past(pop_ok))
      else $error("device queued an out request");

   a_fifo_free_bound: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      f_free_q != $past(f_free_q) |-> f_free_q <= $past(np_q.depth))
      else $error("free words past depth");

   sequence s_cfg_write;
      reg_wr && reg_addr == `UFPC_OFF_CORE_CFG;
   endsequence

   sequence s_ident_write;
      reg_wr && reg_addr == `UFPC_OFF_IDENT;
   endsequence

   sequence s_ident_read;
      reg_rd && reg_addr == `UFPC_OFF_IDENT;
   endsequence

   a_supply_forced: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      s_cfg_write ##2 1'b1
      |-> supply_forced_valid == $past(reg_wdata[`UFPC_CFG_SENSE_DIS], 2))
      else $error("supply force not applied");

   a_power_follow: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      core_cfg.transceiver_power_on == $past(cfg_q[`UFPC_CFG_PWR_ON]))
      else $error("transceiver power mismatch");

   a_ident_readback: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      s_ident_write ##1 !reg_wr ##1 s_ident_read
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("ident readback wrong");

endmodule // ufpc_regs

// file: logic/ufpc_regs.svh
// Purpose: Offsets, field positions, reset values for the FIFO partition
//          and core configuration register group
// Assumes: Byte addresses on a plain register port, one word per register
// Notes:   Included by the bench and the register block
//
// What this block does
// - Receive depth in bits 15:0, any 16-bit value stored
// - Receive size register resets to 0x00000200
// - Host: non-periodic depth high, start low
// - Device: same register defines endpoint-0 FIFO
// - Queue status read-only, reset 0x00080200, device-invalid
// - Queue top: number, type, terminate in 30:24
// - Types 00 token, 01 zero-length, 11 halt
// - Bits 23:16 free queue entries, 0 to 8
// - Host queues IN and OUT, device IN only
// - Bits 15:0 free FIFO words, 0x0200 at reset, then 0 to 256
// - Bit 21 forces supply valid, stops sensing
// - Bit 20 routes frame pulse to pad
// - Bit 19 B-role sensing, bit 18 A-role
// - Bit 16 one powers transceiver on
// - Ident register fully writable and readable
// - Periodic depth high (any 16-bit value stored, no minimum), start low
// - Periodic size register resets to 0x02000600
`ifndef UFPC_REGS_SVH
`define UFPC_REGS_SVH

`define UFPC_ADDR_W          12
`define UFPC_OFF_RX_SIZE     12'h024
`define UFPC_OFF_NP_SIZE     12'h028
`define UFPC_OFF_NP_STATUS   12'h02c
`define UFPC_OFF_CORE_CFG    12'h038
`define UFPC_OFF_IDENT       12'h03c
`define UFPC_OFF_PER_SIZE    12'h100

`define UFPC_RST_RX_SIZE     32'h0000_0200
`define UFPC_RST_NP_SIZE     32'h0000_0200
`define UFPC_RST_NP_STATUS   32'h0008_0200
`define UFPC_RST_CORE_CFG    32'h0000_0000
// Arbitrary neutral ident value
`define UFPC_RST_IDENT       32'h0000_0000
`define UFPC_RST_PER_SIZE    32'h0200_0600

`define UFPC_CFG_SENSE_DIS   21
`define UFPC_CFG_SOF_PAD     20
`define UFPC_CFG_B_SENSE     19
`define UFPC_CFG_A_SENSE     18
`define UFPC_CFG_PWR_ON      16
`define UFPC_CFG_MASK        32'h003d_0000

`define UFPC_QUEUE_DEPTH     8'h08
`define UFPC_DEPTH_MIN       16'h0010
`define UFPC_DEPTH_MAX       16'h0100
`define UFPC_RX_MASK         32'h0000_ffff

`endif
